// ---- ccc_top.sv ----
// charge cycle sequencer with dead time, termination gating, management and ovp
// assumes all inputs synchronous to clk_sys; voltages in mV, currents in raw codes
`timescale 1ns/10ps
module ccc_top #(
	parameter int DEAD_CYC = ccc_pkg::DEAD_CYCLES,
	parameter int CUR_W = ccc_pkg::CUR_W,
	parameter int TMR_W = ccc_pkg::TMR_W
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clk_en,
	// analog measurements in mV and current codes
	input wire logic [12:0] vin_mv,
	input wire logic [12:0] vbat_mv,
	input wire logic [12:0] system_rail_mv,
	input wire logic [CUR_W-1:0] charge_current,
	input wire logic input_valid,
	input wire logic cv_loop_active,
	input wire logic thermal_reg_active,
	input wire logic battery_warm,
	input wire logic zone_change,
	// host configuration
	input wire logic charge_enable_n,
	input wire logic charge_inhibit,
	input wire logic [12:0] low_battery_threshold,
	input wire logic [12:0] battery_regulation_voltage,
	input wire logic [CUR_W-1:0] precharge_current,
	input wire logic [CUR_W-1:0] fast_charge_current,
	input wire logic [CUR_W-1:0] zone_current,
	input wire logic zone_limit,
	input wire logic [CUR_W-1:0] termination_current,
	input wire logic input_mgmt_enable,
	input wire logic [2:0] input_management_threshold,
	input wire logic rail_tracks_battery,
	input wire logic double_timer_option,
	input wire logic [TMR_W-1:0] safety_limit,
	input wire logic [12:0] supplement_entry_threshold,
	input wire logic [12:0] supplement_exit_threshold,
	input wire logic flag_read,
	// outputs
	output logic [CUR_W-1:0] charge_current_set,
	output logic charge_switch_on,
	output logic battery_switch_on,
	output logic input_switch_on,
	output logic high_z,
	output logic supplement_active,
	output logic ocp_enable,
	output logic input_mgmt_status,
	output logic input_mgmt_flag,
	output logic path_mgmt_status,
	output logic path_mgmt_flag,
	output logic ovp_status,
	output logic ovp_flag,
	output logic int_n,
	output logic safety_fault,
	output logic [2:0] charge_state
);
	ccc_pkg::ccc_state_t state_ff, nxt_state;
	logic [CUR_W-1:0] cur_ff, nxt_cur, target;
	logic [15:0] dead_ff;
	logic [TMR_W-1:0] tmr_ff;
	logic tmr_half_ff;
	logic [11:0] int_cnt_ff;
	logic ovp_now, en_chg, imgmt, pmgmt, term_ok, tmr_lim, ext;
	logic [12:0] dpm_mv;

	// over-voltage and enable combination
	assign ovp_now = vin_mv > 13'(ccc_pkg::OVP_MV); // R20
	assign en_chg = !charge_enable_n && !charge_inhibit && input_valid && !ovp_now; // R22
	// input management threshold 4.2 V + code * 100 mV, off until enabled
	assign dpm_mv = 13'(ccc_pkg::VIN_DPM_BASE_MV) +
		13'(input_management_threshold * ccc_pkg::VIN_DPM_STEP_MV); // R10
	assign imgmt = input_mgmt_enable && (vin_mv <= dpm_mv); // R9 R10
	// path management below battery + 200 mV unless rail tracks battery
	assign pmgmt = !rail_tracks_battery &&
		(14'(system_rail_mv) < 14'(vbat_mv) + 14'(ccc_pkg::POWER_PATH_MANAGEMENT_MARGIN_MV)); // R11
	// termination qualification
	assign term_ok = (state_ff == ccc_pkg::CCC_FAST_CV) && cv_loop_active && !imgmt && !pmgmt
		&& !thermal_reg_active && !battery_warm && !supplement_active
		&& (charge_current <= termination_current) && (dead_ff == 16'h0000); // R5 R7 R8 R12 R16
	// precharge limit is a quarter of fast limit
	assign tmr_lim = (tmr_ff >= ((state_ff == ccc_pkg::CCC_PRE) ? (safety_limit >> 2) : safety_limit)); // R2
	assign ext = double_timer_option && (imgmt || pmgmt); // R13

	// target current per phase
	always_comb begin
		target = fast_charge_current; // R3
		if (state_ff == ccc_pkg::CCC_PRE) begin
			target = precharge_current; // R1
		end else if (zone_limit) begin
			target = zone_current;
		end
	end

	// charge state transitions
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ccc_pkg::CCC_IDLE: if (en_chg) nxt_state = (vbat_mv < low_battery_threshold) ?
				ccc_pkg::CCC_PRE : ccc_pkg::CCC_FAST_CC;
			ccc_pkg::CCC_PRE: if (vbat_mv >= low_battery_threshold) nxt_state = ccc_pkg::CCC_FAST_CC; // R1
			ccc_pkg::CCC_FAST_CC: if (cv_loop_active) nxt_state = ccc_pkg::CCC_FAST_CV;
			ccc_pkg::CCC_FAST_CV: begin
				if (term_ok) nxt_state = ccc_pkg::CCC_DONE; // R5
				else if (!cv_loop_active) nxt_state = ccc_pkg::CCC_FAST_CC;
			end
			ccc_pkg::CCC_DONE: ;
			ccc_pkg::CCC_FAULT: ;
			default: nxt_state = ccc_pkg::CCC_IDLE;
		endcase
		if ((state_ff == ccc_pkg::CCC_PRE || state_ff == ccc_pkg::CCC_FAST_CC ||
			state_ff == ccc_pkg::CCC_FAST_CV) && tmr_lim) nxt_state = ccc_pkg::CCC_FAULT;
		if (!en_chg) nxt_state = ccc_pkg::CCC_IDLE;
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state_ff <= ccc_pkg::CCC_IDLE;
		end else if (clk_en) begin
			state_ff <= nxt_state;
		end
	end

	// dead time on any change of current setting
	assign nxt_cur = target;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cur_ff <= '0;
			dead_ff <= 16'h0000;
		end else if (clk_en) begin
			if (target != cur_ff && dead_ff == 16'h0000) begin
				dead_ff <= 16'(DEAD_CYC); // R4
			end else if (dead_ff == 16'h0001) begin
				dead_ff <= 16'h0000;
				cur_ff <= nxt_cur; // R4
			end else if (dead_ff != 16'h0000) begin
				dead_ff <= dead_ff - 16'h0001;
			end
		end
	end

	// safety timer, half speed when extended
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			tmr_ff <= '0;
			tmr_half_ff <= 1'b0;
			safety_fault <= 1'b0;
		end else if (clk_en) begin
			tmr_half_ff <= !tmr_half_ff;
			if (!en_chg) begin
				tmr_ff <= '0;
				safety_fault <= 1'b0;
			end else if (state_ff == ccc_pkg::CCC_FAULT) begin
				safety_fault <= 1'b1;
			end else if (state_ff != ccc_pkg::CCC_DONE && (!ext || tmr_half_ff)) begin
				tmr_ff <= tmr_ff + 1'b1; // R13
			end
		end
	end

	// supplement mode with hysteresis
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			supplement_active <= 1'b0;
		end else if (clk_en) begin
			if (14'(system_rail_mv) + 14'(supplement_entry_threshold) < 14'(vbat_mv)) begin
				supplement_active <= 1'b1; // R14
			end else if (14'(system_rail_mv) > 14'(vbat_mv) + 14'(supplement_exit_threshold)) begin
				supplement_active <= 1'b0; // R15
			end
		end
	end

	// switch and status outputs
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			charge_current_set <= '0;
			charge_switch_on <= 1'b0;
			battery_switch_on <= 1'b1;
			input_switch_on <= 1'b0;
			high_z <= 1'b0;
			ocp_enable <= 1'b1;
			input_mgmt_status <= 1'b0;
			path_mgmt_status <= 1'b0;
			ovp_status <= 1'b0;
			charge_state <= ccc_pkg::ST_CODE_IDLE;
		end else if (clk_en) begin
			charge_current_set <= cur_ff;
			// a pending change keeps the switch open, or the old current leaks for a cycle
			charge_switch_on <= en_chg && dead_ff == 16'h0000 && target == cur_ff &&
				(state_ff == ccc_pkg::CCC_PRE || state_ff == ccc_pkg::CCC_FAST_CC ||
				state_ff == ccc_pkg::CCC_FAST_CV); // R4 R22
			battery_switch_on <= state_ff != ccc_pkg::CCC_DONE; // R6
			high_z <= state_ff == ccc_pkg::CCC_DONE; // R6
			input_switch_on <= input_valid && !ovp_now; // R6 R17 R18
			ocp_enable <= 1'b1; // R16
			input_mgmt_status <= imgmt; // R12
			path_mgmt_status <= pmgmt; // R12
			ovp_status <= ovp_now; // R17 R18
			case (state_ff)
				ccc_pkg::CCC_PRE: charge_state <= ccc_pkg::ST_CODE_PRE; // R23
				ccc_pkg::CCC_FAST_CC: charge_state <= ccc_pkg::ST_CODE_CC;
				ccc_pkg::CCC_FAST_CV: charge_state <= ccc_pkg::ST_CODE_CV;
				ccc_pkg::CCC_DONE: charge_state <= ccc_pkg::ST_CODE_DONE;
				ccc_pkg::CCC_FAULT: charge_state <= ccc_pkg::ST_CODE_FAULT;
				default: charge_state <= ccc_pkg::ST_CODE_IDLE;
			endcase
		end
	end

	// sticky flags; set wins over read, ovp flag clears only once condition gone
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			input_mgmt_flag <= 1'b0;
			path_mgmt_flag <= 1'b0;
			ovp_flag <= 1'b0;
		end else if (clk_en) begin
			input_mgmt_flag <= imgmt || (input_mgmt_flag && !flag_read); // R12
			path_mgmt_flag <= pmgmt || (path_mgmt_flag && !flag_read); // R12
			ovp_flag <= ovp_now || (ovp_flag && !flag_read); // R19
		end
	end

	// single 128 us interrupt pulse on ovp rising
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			int_cnt_ff <= 12'h000;
			int_n <= 1'b1;
		end else if (clk_en) begin
			if (ovp_now && !ovp_status && int_cnt_ff == 12'h000) begin
				int_cnt_ff <= 12'(ccc_pkg::INT_CYCLES); // R17
				int_n <= 1'b0;
			end else if (int_cnt_ff > 12'h001) begin
				int_cnt_ff <= int_cnt_ff - 12'h001;
			end else begin
				int_cnt_ff <= 12'h000;
				int_n <= 1'b1;
			end
		end
	end

	// ovp flag survives a read while the fault persists
	ovp_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R19
		(clk_en && ovp_now) |=> ovp_flag)
		else $error("ovp flag not held");
	// interrupt stays low at least 8 cycles after it falls
	int_pulse_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R17
		$fell(int_n) |-> !int_n [*8])
		else $error("interrupt pulse too short");
	// no termination under loops
	term_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R7
		(clk_en && state_ff == ccc_pkg::CCC_FAST_CV && (imgmt || pmgmt || thermal_reg_active))
		|=> state_ff != ccc_pkg::CCC_DONE)
		else $error("termination during limiting loop");
	// warm battery blocks termination
	warm_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R8
		(clk_en && battery_warm && state_ff != ccc_pkg::CCC_DONE) |=> state_ff != ccc_pkg::CCC_DONE)
		else $error("termination while warm");
	// enable combination
	enable_combo_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R22
		(clk_en && (charge_enable_n || charge_inhibit)) |=> !charge_switch_on)
		else $error("charging with enable off");
	// done means high impedance and battery switch open
	done_hiz_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R6
		(clk_en && state_ff == ccc_pkg::CCC_DONE) |=> (high_z && !battery_switch_on))
		else $error("done without high impedance");
	// current change holds charging off
	dead_time_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R4
		(clk_en && (dead_ff != 16'h0000 || target != cur_ff)) |=> !charge_switch_on)
		else $error("charging during dead time");
	// ovp status follows condition
	ovp_status_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R18
		clk_en |=> (ovp_status == $past(ovp_now) && !(ovp_status && input_switch_on)))
		else $error("ovp status mismatch");
	// management off after reset until enabled
	mgmt_off_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R9
		(clk_en && !input_mgmt_enable) |=> !input_mgmt_status)
		else $error("input management without enable");
	// precharge applies the precharge current once settled
	pre_current_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R1
		(clk_en && state_ff == ccc_pkg::CCC_PRE && dead_ff == 16'h0000 && cur_ff == target)
		|=> charge_current_set == $past(precharge_current))
		else $error("precharge current not applied");
	// precharge faults at a quarter of the limit
	pre_limit_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R2
		(clk_en && en_chg && state_ff == ccc_pkg::CCC_PRE && tmr_ff >= (safety_limit >> 2))
		|=> state_ff == ccc_pkg::CCC_FAULT)
		else $error("precharge limit not applied");
	// path management raises status and flag
	path_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R12
		(clk_en && pmgmt) |=> (path_mgmt_status && path_mgmt_flag))
		else $error("path management not reported");
	// rail far below battery enters supplement
	supp_entry_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R14
		(clk_en && 14'(system_rail_mv) + 14'(supplement_entry_threshold) < 14'(vbat_mv))
		|=> supplement_active)
		else $error("supplement not entered");
	// rail well above battery leaves supplement
	supp_exit_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R15
		(clk_en && 14'(system_rail_mv) > 14'(vbat_mv) + 14'(supplement_exit_threshold))
		|=> !supplement_active)
		else $error("supplement not left");
endmodule : ccc_top

// ---- ccc_pkg.sv ----
// constants, state encoding and timing counts for the charge cycle controller
// assumes a single 10 MHz system clock and digital comparator results as inputs
// What this block does
// [R1] precharge below low threshold, then fast charge
// [R2] precharge safety limit is quarter of fast
// [R3] constant-current loop charges at full fast current; with zone_limit set the code charges at zone_current instead
// [R4] current setting change suspends charging about 1 ms
// [R5] terminate when current falls to termination current
// [R6] after termination go high-impedance, open battery switch
// [R7] terminate only in CV, not during limiting loops
// [R8] no termination while battery is warm
// [R9] input voltage management off until host enables
// [R10] input threshold 4.2 to 4.9 V, 100 mV
// [R11] path management below battery plus 200 mV
// [R12] management active sets status, flags, blocks termination
// [R13] double timer extends safety timer while loops active
// [R14] enter supplement when rail below battery minus entry
// [R15] leave supplement when rail above battery plus exit
// [R16] supplement keeps over-current protection, blocks termination
// [R17] over-voltage opens input switch, 128 us pulse, flags
// [R18] over-voltage removal clears status, resumes automatically
// [R19] fault flag clears on read after condition ends
// [R20] over-voltage threshold is 5.5 V
// [R21] host sets rail at least 200 mV above regulation
// [R22] charge only with enable pin low and inhibit zero
// [R23] charge state encoded in readable status field
package ccc_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int DEAD_TIME_US = 1000;
	localparam int DEAD_CYCLES = (DEAD_TIME_US * (CLK_HZ / 1_000_000) + 0);
	localparam int INT_PULSE_US = 128;
	localparam int INT_CYCLES = INT_PULSE_US * (CLK_HZ / 1_000_000);
	localparam int OVP_MV = 5500;
	localparam int POWER_PATH_MANAGEMENT_MARGIN_MV = 200;
	localparam int VIN_DPM_BASE_MV = 4200;
	localparam int VIN_DPM_STEP_MV = 100;
	localparam logic [2:0] VIN_DPM_MAX_CODE = 3'h7;
	localparam int MV_W = 13;
	localparam int CUR_W = 10;
	localparam int TMR_W = 24;
	localparam logic [TMR_W-1:0] SAFETY_LIMIT_RST = 24'h000fff;
	typedef enum logic [2:0] {
		CCC_IDLE,
		CCC_PRE,
		CCC_FAST_CC,
		CCC_FAST_CV,
		CCC_DONE,
		CCC_FAULT
	} ccc_state_t;
	localparam logic [2:0] ST_CODE_IDLE = 3'h0;
	localparam logic [2:0] ST_CODE_PRE = 3'h1;
	localparam logic [2:0] ST_CODE_CC = 3'h2;
	localparam logic [2:0] ST_CODE_CV = 3'h3;
	localparam logic [2:0] ST_CODE_DONE = 3'h4;
	localparam logic [2:0] ST_CODE_FAULT = 3'h5;
endpackage : ccc_pkg

// ---- ccc_supply_model.sv ----
// supply, battery and system rail seen by the charger: measured levels and current
// assumes the bench sets target levels; sensed current follows the charge switch
`timescale 1ns/10ps
module ccc_supply_model (
	// clock
	input wire logic clk_sys,
	// targets from the bench
	input wire logic [12:0] vin_req,
	input wire logic [12:0] vbat_req,
	input wire logic [12:0] rail_req,
	input wire logic taper,
	// from the charger
	input wire logic charge_switch_on,
	input wire logic [9:0] charge_current_set,
	// measured values
	output logic [12:0] vin_mv,
	output logic [12:0] vbat_mv,
	output logic [12:0] system_rail_mv,
	output logic [9:0] charge_current
);
	// levels settle one cycle after the target moves
	always_ff @(posedge clk_sys) begin
		vin_mv <= vin_req;
		vbat_mv <= vbat_req;
		system_rail_mv <= rail_req;
	end
	// no current with the switch open; tapers to zero once the cell is full
	always_ff @(posedge clk_sys) begin
		charge_current <= (charge_switch_on && !taper) ? charge_current_set : 10'h000;
	end
endmodule : ccc_supply_model

// ---- testbench.sv ----
// self-checking bench for the charge cycle controller with a supply model
// assumes a short dead time parameter and the two-cycle answer of the outputs
`timescale 1ns/10ps
module testbench;
	logic clk_sys, nrst, clk_en, input_valid, cv_loop_active, thermal_reg_active, battery_warm;
	logic zone_change, charge_enable_n, charge_inhibit, zone_limit, input_mgmt_enable;
	logic rail_tracks_battery, double_timer_option, flag_read, taper;
	logic [12:0] vin_req, vbat_req, rail_req, vin_mv, vbat_mv, system_rail_mv;
	logic [12:0] low_battery_threshold, battery_regulation_voltage;
	logic [12:0] supplement_entry_threshold, supplement_exit_threshold;
	logic [9:0] charge_current, precharge_current, fast_charge_current, zone_current;
	logic [9:0] termination_current, charge_current_set;
	logic [2:0] input_management_threshold, charge_state;
	logic [23:0] safety_limit;
	logic charge_switch_on, battery_switch_on, input_switch_on, high_z, supplement_active;
	logic ocp_enable, input_mgmt_status, input_mgmt_flag, path_mgmt_status, path_mgmt_flag;
	logic ovp_status, ovp_flag, int_n, safety_fault;
	int fails = 0;
	int cmp_count = 0;
	int thr;
	ccc_supply_model ccc_supply_model_i (.clk_sys(clk_sys), .vin_req(vin_req),
		.vbat_req(vbat_req), .rail_req(rail_req), .taper(taper),
		.charge_switch_on(charge_switch_on), .charge_current_set(charge_current_set),
		.vin_mv(vin_mv), .vbat_mv(vbat_mv), .system_rail_mv(system_rail_mv),
		.charge_current(charge_current));
	ccc_top #(.DEAD_CYC(20)) ccc_top_i (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
		.vin_mv(vin_mv), .vbat_mv(vbat_mv), .system_rail_mv(system_rail_mv),
		.charge_current(charge_current), .input_valid(input_valid),
		.cv_loop_active(cv_loop_active), .thermal_reg_active(thermal_reg_active),
		.battery_warm(battery_warm), .zone_change(zone_change),
		.charge_enable_n(charge_enable_n), .charge_inhibit(charge_inhibit),
		.low_battery_threshold(low_battery_threshold),
		.battery_regulation_voltage(battery_regulation_voltage),
		.precharge_current(precharge_current), .fast_charge_current(fast_charge_current),
		.zone_current(zone_current), .zone_limit(zone_limit),
		.termination_current(termination_current), .input_mgmt_enable(input_mgmt_enable),
		.input_management_threshold(input_management_threshold),
		.rail_tracks_battery(rail_tracks_battery), .double_timer_option(double_timer_option),
		.safety_limit(safety_limit), .supplement_entry_threshold(supplement_entry_threshold),
		.supplement_exit_threshold(supplement_exit_threshold), .flag_read(flag_read),
		.charge_current_set(charge_current_set), .charge_switch_on(charge_switch_on),
		.battery_switch_on(battery_switch_on), .input_switch_on(input_switch_on),
		.high_z(high_z), .supplement_active(supplement_active), .ocp_enable(ocp_enable),
		.input_mgmt_status(input_mgmt_status), .input_mgmt_flag(input_mgmt_flag),
		.path_mgmt_status(path_mgmt_status), .path_mgmt_flag(path_mgmt_flag),
		.ovp_status(ovp_status), .ovp_flag(ovp_flag), .int_n(int_n),
		.safety_fault(safety_fault), .charge_state(charge_state));
	// compare one value and count it
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// let n edges pass, then sample settled outputs
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	// one host read strobe of the flags
	task automatic read_flags;
		@(posedge clk_sys) flag_read <= 1'b1;
		@(posedge clk_sys) flag_read <= 1'b0;
	endtask : read_flags
	task automatic end_of_test;
		$display("compares=%0d fails=%0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test
	// 10 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		end_of_test();
	end
	// main sequence; the rail is kept 400 mV over regulation in normal use
	initial begin
		void'($urandom(32'hd69a));
		{nrst, clk_en, input_valid, cv_loop_active, thermal_reg_active} = 5'h0c;
		{battery_warm, zone_change, charge_enable_n, charge_inhibit, zone_limit} = 5'h04;
		{input_mgmt_enable, rail_tracks_battery, flag_read, taper} = 4'h0;
		double_timer_option = 1'($urandom_range(1, 0));
		{vin_req, vbat_req, rail_req} = {13'h1388, 13'h0af0, 13'h11f8};
		{low_battery_threshold, battery_regulation_voltage} = {13'h0bb8, 13'h1068};
		{supplement_entry_threshold, supplement_exit_threshold} = {13'h0028, 13'h0064};
		precharge_current = 10'($urandom_range(50, 10));
		fast_charge_current = 10'($urandom_range(400, 200));
		{zone_current, termination_current, safety_limit} = {10'h010, 10'h008, 24'h000190};
		input_management_threshold = 3'($urandom_range(7, 0));
		thr = 4200 + 100 * input_management_threshold;
		step(10);
		chk({battery_switch_on, ocp_enable, int_n, charge_switch_on}, 4'he);
		chk(charge_state, ccc_pkg::ST_CODE_IDLE);
		@(posedge clk_sys) {nrst, charge_enable_n, charge_inhibit} <= 3'h5;
		step(30);
		chk({charge_switch_on, charge_state}, {1'b0, ccc_pkg::ST_CODE_IDLE});
		@(posedge clk_sys) charge_inhibit <= 1'b0;
		step(30);
		chk({charge_switch_on, charge_state}, {1'b1, ccc_pkg::ST_CODE_PRE});
		chk(charge_current_set, precharge_current);
		step(110);
		chk({safety_fault, charge_state}, {1'b1, ccc_pkg::ST_CODE_FAULT});
		@(posedge clk_sys) {charge_enable_n, safety_limit} <= {1'b1, 24'hffffff};
		step(5);
		@(posedge clk_sys) charge_enable_n <= 1'b0;
		step(30);
		chk(charge_state, ccc_pkg::ST_CODE_PRE);
		@(posedge clk_sys) vbat_req <= 13'h0e74;
		step(5);
		chk(charge_switch_on, 1'b0);
		step(30);
		chk({charge_switch_on, charge_state}, {1'b1, ccc_pkg::ST_CODE_CC});
		chk(charge_current_set, fast_charge_current);
		@(posedge clk_sys) fast_charge_current <= fast_charge_current + 10'h001;
		step(5);
		chk(charge_switch_on, 1'b0);
		step(30);
		chk(charge_current_set, fast_charge_current);
		@(posedge clk_sys) zone_limit <= 1'b1;
		step(5);
		chk(charge_switch_on, 1'b0);
		step(30);
		chk({charge_switch_on, charge_current_set}, {1'b1, zone_current});
		@(posedge clk_sys) zone_limit <= 1'b0;
		step(35);
		chk({charge_switch_on, charge_current_set}, {1'b1, fast_charge_current});
		@(posedge clk_sys) {cv_loop_active, battery_warm, taper} <= 3'h7;
		step(10);
		chk({high_z, charge_state}, {1'b0, ccc_pkg::ST_CODE_CV});
		@(posedge clk_sys) {battery_warm, thermal_reg_active} <= 2'h1;
		step(10);
		chk(charge_state, ccc_pkg::ST_CODE_CV);
		@(posedge clk_sys) rail_req <= 13'h0ed8;
		@(posedge clk_sys) thermal_reg_active <= 1'b0;
		step(10);
		chk({path_mgmt_status, path_mgmt_flag, charge_state}, {2'h3, ccc_pkg::ST_CODE_CV});
		@(posedge clk_sys) rail_tracks_battery <= 1'b1;
		step(10);
		chk({path_mgmt_status, charge_state}, {1'b0, ccc_pkg::ST_CODE_DONE});
		chk({high_z, battery_switch_on, input_switch_on}, 3'h5);
		@(posedge clk_sys) input_valid <= 1'b0;
		step(10);
		chk(input_switch_on, 1'b0);
		@(posedge clk_sys) {input_valid, rail_req} <= {1'b1, 13'h0e10};
		step(10);
		chk({supplement_active, ocp_enable}, 2'h3);
		@(posedge clk_sys) rail_req <= 13'h0ea6;
		step(10);
		chk({supplement_active, ocp_enable}, 2'h3);
		@(posedge clk_sys) rail_req <= 13'h0f0a;
		step(10);
		chk(supplement_active, 1'b0);
		@(posedge clk_sys) vin_req <= 13'(thr - 50);
		step(10);
		chk(input_mgmt_status, 1'b0);
		@(posedge clk_sys) input_mgmt_enable <= 1'b1;
		step(10);
		chk({input_mgmt_status, input_mgmt_flag}, 2'h3);
		@(posedge clk_sys) vin_req <= 13'(thr + 50);
		step(10);
		chk(input_mgmt_status, 1'b0);
		@(posedge clk_sys) vin_req <= 13'h157c;
		step(10);
		chk(ovp_status, 1'b0);
		@(posedge clk_sys) vin_req <= 13'h157d;
		step(10);
		chk({ovp_status, ovp_flag, input_switch_on, int_n}, 4'hc);
		step(1260);
		chk(int_n, 1'b0);
		step(20);
		chk(int_n, 1'b1);
		read_flags();
		step(5);
		chk(ovp_flag, 1'b1);
		chk({input_mgmt_flag, path_mgmt_flag}, 2'h0);
		@(posedge clk_sys) vin_req <= 13'h1388;
		step(10);
		chk({ovp_status, ovp_flag, input_switch_on}, 3'h3);
		read_flags();
		step(5);
		chk(ovp_flag, 1'b0);
		end_of_test();
	end
endmodule : testbench
